// ==== verilog/external_external_data_move_bus_interface.sv ====
// external data move bus controller with on-chip auxiliary ram
//
// Functional notes
// - latch phase stretch of zero to three
// - strobe width stretch of zero to seven
// - strobe setup/hold stretch of zero or one
// - address driven one plus latch stretch early
// - address held one plus latch stretch after
// - strobe starts 2+2M+L after latch falls
// - read releases bus before read strobe
// - read data sampled 1+N after strobe
// - write data valid 1+L before strobe
// - write data valid 2+L+N before release
// - wait 1+L after strobe before next latch
// - external moves take three to twenty-three cycles
// - on-chip moves take three cycles, no bus
// - access duration set by mode and stretches
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "ext_bus_params.svh"

module external_external_data_move_bus_interface
  import ext_bus_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] ad_in,
  output logic [7:0] ad_out,
  output logic ad_oe,
  output logic [7:0] addr_high,
  output logic ale,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic busy
);
  import ext_bus_pkg::*;

  state_type state_reg;
  state_type state_next;

  // cycles a phase lasts, minus one, as the counter preload
  function automatic logic [2:0] phase_preload(
    input phase_type phase,
    input logic [1:0] m,
    input logic [2:0] n,
    input logic l
  );
    logic [2:0] value;
    value = 3'h0;
    case (phase)
      phase_latch: value = {1'b0, m};
      phase_addr_hold: value = {1'b0, m};
      phase_gap: value = {1'b0, m} - 3'h1;
      phase_setup: value = {2'b00, l};
      phase_strobe: value = n;
      phase_post: value = {2'b00, l};
      phase_on_chip: value = `ON_CHIP_PRELOAD;
      default: value = 3'h0;
    endcase
    return value;
  endfunction

  // phase that follows once the current one has run out
  function automatic phase_type phase_after(
    input phase_type phase,
    input logic [1:0] m
  );
    phase_type value;
    value = phase_idle;
    case (phase)
      phase_latch: value = phase_addr_hold;
      phase_addr_hold: value = (m != 2'b00) ? phase_gap : phase_setup;
      phase_gap: value = phase_setup;
      phase_setup: value = phase_strobe;
      phase_strobe: value = phase_post;
      phase_post: value = phase_idle;
      phase_on_chip: value = phase_idle;
      default: value = phase_idle;
    endcase
    return value;
  endfunction

  // a strobe is low only in the strobe phase of an access of its own direction;
  // both pins share this one decode, so they can never be low together
  function automatic logic strobe_active(
    input phase_type phase,
    input logic is_write,
    input logic want_write
  );
    return (phase == phase_strobe) && (is_write == want_write);
  endfunction

  logic is_busy;
  logic last_cycle;
  phase_type start_phase;

  assign is_busy = (state_reg.phase != phase_idle);
  // the counter holds the cycles left in the phase, minus one
  assign last_cycle = (state_reg.count == 3'h0);

  // short mode skips the latch and address phases altogether
  assign start_phase = reg_wdata[`CMD_ON_CHIP_BIT] ? phase_on_chip :
                       state_reg.short_access_mode_bit ? phase_setup : phase_latch;

  always_comb begin
    state_next = state_reg;

    // sequencing of a running access
    if (is_busy) begin
      if (!last_cycle) begin
        state_next.count = state_reg.count - 3'h1;
      end else begin
        state_next.phase = phase_after(state_reg.phase, state_reg.latch_stretch);
        state_next.count = phase_preload(state_next.phase, state_reg.latch_stretch,
                                         state_reg.width_stretch,
                                         state_reg.strobe_setup_hold_extension);
      end
      if (!(last_cycle && phase_after(state_reg.phase, state_reg.latch_stretch)
            == phase_idle)) begin
        state_next.duration = state_reg.duration + 5'h01;
      end else begin
        state_next.done = 1'b1;
      end
      // read data is taken at the end of the widened strobe
      if (state_reg.phase == phase_strobe && last_cycle && !state_reg.is_write) begin
        state_next.read_data = ad_in;
      end
      if (state_reg.phase == phase_on_chip && last_cycle) begin
        if (state_reg.is_write) begin
          state_next.aux_ram[state_reg.address[`AUX_RAM_ADDR_BITS-1:0]] =
            state_reg.write_data;
        end else begin
          state_next.read_data =
            state_reg.aux_ram[state_reg.address[`AUX_RAM_ADDR_BITS-1:0]];
        end
      end
    end

    // register writes; settings are frozen while an access runs
    if (reg_write) begin
      case (reg_addr)
        `REG_CONFIG: begin
          // a refused write leaves the running access untouched
          if (is_busy) begin
            state_next.refused = 1'b1;
          end else begin
            state_next.latch_stretch = reg_wdata[`CFG_LATCH_MSB:`CFG_LATCH_LSB];
            state_next.width_stretch = reg_wdata[`CFG_WIDTH_MSB:`CFG_WIDTH_LSB];
            state_next.strobe_setup_hold_extension =
              reg_wdata[`CFG_SETUP_HOLD_BIT];
            state_next.short_access_mode_bit = reg_wdata[`CFG_SHORT_MODE_BIT];
          end
        end
        `REG_ADDR_LOW: begin
          if (is_busy) begin
            state_next.refused = 1'b1;
          end else begin
            state_next.address[7:0] = reg_wdata;
          end
        end
        `REG_ADDR_HIGH: begin
          if (is_busy) begin
            state_next.refused = 1'b1;
          end else begin
            state_next.address[15:8] = reg_wdata;
          end
        end
        `REG_WRITE_DATA: begin
          if (is_busy) begin
            state_next.refused = 1'b1;
          end else begin
            state_next.write_data = reg_wdata;
          end
        end
        `REG_COMMAND: begin
          // a second access is not queued, it is refused
          if (is_busy) begin
            state_next.refused = 1'b1;
          end else begin
            state_next.phase = start_phase;
            state_next.count = phase_preload(start_phase, state_reg.latch_stretch,
                                             state_reg.width_stretch,
                                             state_reg.strobe_setup_hold_extension);
            state_next.is_write = reg_wdata[`CMD_WRITE_BIT];
            state_next.wide_addr = reg_wdata[`CMD_WIDE_ADDR_BIT];
            state_next.done = 1'b0;
            state_next.duration = 5'h01;
          end
        end
        `REG_STATUS: begin
          // write one to clear; a refusal needs a write to another index, so none collides
          if (reg_wdata[`STAT_REFUSED_BIT]) begin
            state_next.refused = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // register reads answer one cycle later
    if (reg_read) begin
      case (reg_addr)
        `REG_CONFIG: state_next.reg_rdata = {1'b0, state_reg.short_access_mode_bit,
                                             state_reg.strobe_setup_hold_extension,
                                             state_reg.width_stretch,
                                             state_reg.latch_stretch};
        `REG_ADDR_LOW: state_next.reg_rdata = state_reg.address[7:0];
        `REG_ADDR_HIGH: state_next.reg_rdata = state_reg.address[15:8];
        `REG_WRITE_DATA: state_next.reg_rdata = state_reg.write_data;
        `REG_COMMAND: state_next.reg_rdata = {5'h00, state_reg.phase == phase_on_chip,
                                              state_reg.wide_addr, state_reg.is_write};
        `REG_STATUS: state_next.reg_rdata = {5'h00, state_reg.refused, state_reg.done,
                                             is_busy};
        `REG_READ_DATA: state_next.reg_rdata = state_reg.read_data;
        `REG_DURATION: state_next.reg_rdata = {3'h0, state_reg.duration};
        default: state_next.reg_rdata = 8'h00;
      endcase
    end else begin
      state_next.reg_rdata = 8'h00;
    end

    // pin levels follow the phase being entered, so they leave flip-flops
    state_next.ale = (state_next.phase == phase_latch);
    state_next.busy = (state_next.phase != phase_idle);
    // only one strobe exists per access, decoded from one phase
    state_next.read_strobe_n =
      !strobe_active(state_next.phase, state_next.is_write, 1'b0);
    state_next.write_strobe_n =
      !strobe_active(state_next.phase, state_next.is_write, 1'b1);
    case (state_next.phase)
      phase_latch, phase_addr_hold: begin
        state_next.ad_oe = 1'b1;
        state_next.ad_out = state_next.address[7:0];
      end
      phase_setup, phase_strobe, phase_post: begin
        // on a read the bus is already released when the strobe falls
        state_next.ad_oe = state_next.is_write;
        state_next.ad_out = state_next.is_write ? state_next.write_data : 8'h00;
      end
      default: begin
        state_next.ad_oe = 1'b0;
        state_next.ad_out = 8'h00;
      end
    endcase
    // narrow addressing leaves the high address port at zero
    if (state_next.phase != phase_idle && state_next.phase != phase_on_chip &&
        state_next.wide_addr) begin
      state_next.addr_high = state_next.address[15:8];
    end else begin
      state_next.addr_high = 8'h00;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg.phase <= phase_idle;
      state_reg.count <= 3'h0;
      state_reg.latch_stretch <= 2'(`CFG_RESET);
      state_reg.width_stretch <= 3'h0;
      state_reg.strobe_setup_hold_extension <= 1'b0;
      state_reg.short_access_mode_bit <= 1'b0;
      state_reg.address <= 16'h0000;
      state_reg.write_data <= 8'h00;
      state_reg.is_write <= 1'b0;
      state_reg.wide_addr <= 1'b0;
      state_reg.read_data <= 8'h00;
      state_reg.done <= 1'b0;
      state_reg.refused <= 1'b0;
      state_reg.duration <= 5'h00;
      state_reg.reg_rdata <= 8'h00;
      state_reg.ale <= 1'b0;
      state_reg.read_strobe_n <= 1'b1;
      state_reg.write_strobe_n <= 1'b1;
      state_reg.busy <= 1'b0;
      state_reg.ad_out <= 8'h00;
      state_reg.ad_oe <= 1'b0;
      state_reg.addr_high <= 8'h00;
      state_reg.aux_ram <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata = state_reg.reg_rdata;
  assign ad_out = state_reg.ad_out;
  assign ad_oe = state_reg.ad_oe;
  assign addr_high = state_reg.addr_high;
  assign ale = state_reg.ale;
  assign read_strobe_n = state_reg.read_strobe_n;
  assign write_strobe_n = state_reg.write_strobe_n;
  // busy has its own flip-flop that tracks the phase being entered
  assign busy = state_reg.busy;

endmodule

// ==== verilog/ext_bus_params.svh ====
// constants for the external data move bus controller
`ifndef EXT_BUS_PARAMS_SVH
`define EXT_BUS_PARAMS_SVH

// register indices on the 4-bit register port
`define REG_CONFIG 4'h0
`define REG_ADDR_LOW 4'h1
`define REG_ADDR_HIGH 4'h2
`define REG_WRITE_DATA 4'h3
`define REG_COMMAND 4'h4
`define REG_STATUS 4'h5
`define REG_READ_DATA 4'h6
`define REG_DURATION 4'h7

// config field positions
`define CFG_LATCH_LSB 0
`define CFG_LATCH_MSB 1
`define CFG_WIDTH_LSB 2
`define CFG_WIDTH_MSB 4
`define CFG_SETUP_HOLD_BIT 5
`define CFG_SHORT_MODE_BIT 6
`define CFG_RESET 8'h00

// command field positions
`define CMD_WRITE_BIT 0
`define CMD_WIDE_ADDR_BIT 1
`define CMD_ON_CHIP_BIT 2

// status field positions
`define STAT_BUSY_BIT 0
`define STAT_DONE_BIT 1
`define STAT_REFUSED_BIT 2

// on-chip auxiliary ram
`define AUX_RAM_DEPTH 64
`define AUX_RAM_ADDR_BITS 6

// fixed on-chip access time in cycles, and its counter preload
`define ON_CHIP_CYCLES 3
`define ON_CHIP_PRELOAD 3'h2

`endif

// ==== verilog/ext_bus_pkg.sv ====
// types for the external data move bus controller
`include "ext_bus_params.svh"

package ext_bus_pkg;

  typedef enum logic [2:0] {
    phase_idle = 3'b000,
    phase_latch = 3'b001,
    phase_addr_hold = 3'b010,
    phase_gap = 3'b011,
    phase_setup = 3'b100,
    phase_strobe = 3'b101,
    phase_post = 3'b110,
    phase_on_chip = 3'b111
  } phase_type;

  typedef struct packed {
    phase_type phase;
    logic [2:0] count;
    logic [1:0] latch_stretch;
    logic [2:0] width_stretch;
    logic strobe_setup_hold_extension;
    logic short_access_mode_bit;
    logic [15:0] address;
    logic [7:0] write_data;
    logic is_write;
    logic wide_addr;
    logic [7:0] read_data;
    logic done;
    logic refused;
    logic [4:0] duration;
    logic [7:0] reg_rdata;
    logic ale;
    logic read_strobe_n;
    logic write_strobe_n;
    logic busy;
    logic [7:0] ad_out;
    logic ad_oe;
    logic [7:0] addr_high;
    logic [`AUX_RAM_DEPTH-1:0][7:0] aux_ram;
  } state_type;

endpackage

// ==== tb/ext_mem_model.sv ====
// far-side memory model on the multiplexed address/data bus
`timescale 1ns/1ps
module ext_mem_model (
  input wire logic clock,
  input wire logic slow,
  input wire logic ale,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [7:0] ad_out,
  input wire logic ad_oe,
  output logic [7:0] ad_in
);
  logic [7:0] mem [256];
  logic [7:0] addr = 8'h00;
  logic [7:0] prev = 8'h00;
  logic [3:0] low_cnt = 4'h0;
  logic give;
  initial foreach (mem[i]) mem[i] = 8'(i) ^ 8'h5A;
  // a slow part shows its data only from the second strobe cycle on
  assign give = !read_strobe_n && (!slow || low_cnt != 4'h0);
  // a released bus flips every cycle so stale data never looks valid
  assign ad_in = ad_oe ? ad_out : (give ? mem[addr] : ~prev);
  always @(posedge clock) begin
    prev <= ad_in;
    low_cnt <= read_strobe_n ? 4'h0 : low_cnt + 4'h1;
    if (ale) addr <= ad_out;
    if (!write_strobe_n) mem[addr] <= ad_in;
  end
endmodule

// ==== tb/ext_bus_checker_props.sv ====
// pin-level checks of the external data move bus controller
`timescale 1ns/1ps
`include "ext_bus_params.svh"
module ext_bus_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] ad_in,
  input wire logic [7:0] ad_out,
  input wire logic ad_oe,
  input wire logic [7:0] addr_high,
  input wire logic ale,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic busy
);
  logic [7:0] cfg, cmd, wd, ah;
  logic [4:0] cyc, low;
  logic idle_strobes;
  int m, n, l, s;
  assign idle_strobes = read_strobe_n & write_strobe_n;
  assign m = int'(cfg[1:0]);
  assign n = int'(cfg[4:2]);
  assign l = int'(cfg[5]);
  assign s = int'(cfg[6]);
  // settings are shadowed only when idle, since the block refuses them while busy
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg <= `CFG_RESET;
      cmd <= 8'h00;
      wd <= 8'h00;
      ah <= 8'h00;
      cyc <= 5'h00;
      low <= 5'h00;
    end else begin
      cyc <= busy ? cyc + 5'h01 : 5'h00;
      low <= idle_strobes ? 5'h00 : low + 5'h01;
      if (reg_write && !busy) begin
        case (reg_addr)
          `REG_CONFIG: cfg <= reg_wdata;
          `REG_ADDR_HIGH: ah <= reg_wdata;
          `REG_WRITE_DATA: wd <= reg_wdata;
          `REG_COMMAND: cmd <= reg_wdata;
          default: ;
        endcase
      end
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_one; read_strobe_n || write_strobe_n; endproperty
  a_one: assert property (p_one) else $error("both strobes low");
  property p_idle; !busy |-> idle_strobes && !ale && !ad_oe; endproperty
  a_idle: assert property (p_idle) else $error("pins move when idle");
  property p_width; $rose(idle_strobes) |-> low == n + 1; endproperty
  a_width: assert property (p_width) else $error("strobe width");
  property p_ale; $fell(ale) |-> cyc == m + 1 && ad_oe; endproperty
  a_ale: assert property (p_ale) else $error("latch phase length");
  property p_hold; $fell(ale) |-> ad_oe && $stable(ad_out); endproperty
  a_hold: assert property (p_hold) else $error("address not held");
  property p_start; $fell(idle_strobes) |-> cyc == (s ? 1 + l : 3 + 3 * m + l); endproperty
  a_start: assert property (p_start) else $error("strobe start");
  property p_rel; !read_strobe_n |-> !ad_oe; endproperty
  a_rel: assert property (p_rel) else $error("bus driven in read");
  property p_wdata; !write_strobe_n |-> ad_oe && ad_out == wd && $past(ad_out) == wd; endproperty
  a_wdata: assert property (p_wdata) else $error("write data");
  property p_post; $rose(idle_strobes) |-> !ale [*2]; endproperty
  a_post: assert property (p_post) else $error("latch too soon");
  property p_len;
    $fell(busy) |-> cyc == (cmd[2] ? 3 : s ? 3 + n + 2 * l : 5 + 3 * m + n + 2 * l);
  endproperty
  a_len: assert property (p_len) else $error("access length");
  property p_chip; busy && cmd[`CMD_ON_CHIP_BIT] |-> idle_strobes && !ale && !ad_oe; endproperty
  a_chip: assert property (p_chip) else $error("pins move on-chip");
  property p_high; !idle_strobes |-> addr_high == (cmd[1] ? ah : 8'h00); endproperty
  a_high: assert property (p_high) else $error("high address");
endmodule
bind external_external_data_move_bus_interface ext_bus_checker chk (.clock, .rst, .reg_addr, .reg_wdata,
  .reg_write, .reg_read, .reg_rdata, .ad_in, .ad_out, .ad_oe, .addr_high, .ale,
  .read_strobe_n, .write_strobe_n, .busy);

// ==== tb/tb_top.sv ====
// self-checking bench for the external data move bus controller
`timescale 1ns/1ps
`include "ext_bus_params.svh"
`define CHK(g, e) begin \
  n_compared++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("unexpected %0t: got %h want %h", $time, g, e); \
  end \
end
module tb_top;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic slow = 1'b0;
  logic [7:0] reg_rdata, ad_in, ad_out, addr_high, v;
  logic ad_oe, ale, read_strobe_n, write_strobe_n, busy;
  int bad_count = 0;
  int n_compared = 0;
  always #4 clock = ~clock;
  external_external_data_move_bus_interface dut (.clock, .rst, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .ad_in, .ad_out, .ad_oe, .addr_high, .ale, .read_strobe_n,
    .write_strobe_n, .busy);
  ext_mem_model far (.clock, .slow, .ale, .read_strobe_n, .write_strobe_n, .ad_out,
    .ad_oe, .ad_in);
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    // an idle edge keeps the strobe from being driven twice in one step
    @(posedge clock);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clock);
  endtask
  // one access; with refuse set, a command and a config write hit it while busy
  task automatic run(input logic [7:0] c, cmd, a, d, input int e, input bit refuse);
    int k;
    wr(`REG_CONFIG, c);
    wr(`REG_ADDR_LOW, a);
    wr(`REG_ADDR_HIGH, 8'hC3);
    wr(`REG_WRITE_DATA, d);
    wr(`REG_COMMAND, cmd);
    k = 1;
    if (refuse) begin
      wr(`REG_COMMAND, 8'h01);
      wr(`REG_CONFIG, 8'h00);
      k = 5;
    end
    #1;
    while (busy !== 1'b0 && k < 40) begin
      @(posedge clock);
      #1;
      k++;
    end
    @(posedge clock);
    `CHK(k, e)
    rd(`REG_DURATION, v);
    `CHK(v, 8'(e))
  endtask
  task automatic t_reset;
    `CHK({ale, read_strobe_n, write_strobe_n, ad_oe, busy}, 5'b01100)
    wr(4'h9, 8'hFF);
    rd(`REG_CONFIG, v);
    `CHK(v, `CFG_RESET)
    rd(4'hF, v);
    `CHK(v, 8'h00)
  endtask
  task automatic t_sweep;
    logic [7:0] t[6] = '{8'h00, 8'h3F, 8'h09, 8'h36, 8'h7C, 8'h40};
    logic [7:0] last;
    int m, n, l, e;
    for (int i = 0; i < 6; i++) begin
      m = int'(t[i][1:0]);
      n = int'(t[i][4:2]);
      l = int'(t[i][5]);
      e = t[i][6] ? 3 + n + 2 * l : 5 + 3 * m + n + 2 * l;
      if (!t[i][6]) last = 8'h10 + 8'(i);
      slow <= (n != 0);
      run(t[i], 8'h00, 8'h10 + 8'(i), 8'h00, e, 1'b0);
      rd(`REG_READ_DATA, v);
      `CHK(v, last ^ 8'h5A)
      rd(`REG_STATUS, v);
      `CHK(v, 8'h02)
    end
  endtask
  task automatic t_write;
    run(8'h09, 8'h03, 8'h80, 8'hA5, 10, 1'b0);
    run(8'h09, 8'h02, 8'h80, 8'h00, 10, 1'b0);
    rd(`REG_READ_DATA, v);
    `CHK(v, 8'hA5)
  endtask
  task automatic t_on_chip;
    run(8'h00, 8'h05, 8'h07, 8'h3C, 3, 1'b0);
    run(8'h00, 8'h04, 8'h07, 8'h00, 3, 1'b0);
    rd(`REG_READ_DATA, v);
    `CHK(v, 8'h3C)
  endtask
  task automatic t_refuse;
    run(8'h3F, 8'h00, 8'h20, 8'h00, 23, 1'b1);
    rd(`REG_STATUS, v);
    `CHK(v, 8'h06)
    wr(`REG_STATUS, 8'h04);
    rd(`REG_STATUS, v);
    `CHK(v, 8'h02)
  endtask
  task automatic end_of_test;
    if (bad_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_reset;
    t_sweep;
    t_write;
    t_on_chip;
    t_refuse;
    end_of_test;
  end
  // the whole run needs well under a thousand cycles
  initial begin
    #100000;
    bad_count++;
    end_of_test;
  end
endmodule
